//--- logic/ctrl_status2_bits.sv
// second control and status register bank with its error flags
`timescale 1ns/1ps
// What this block does
// - set absent_memory when dma memory misses master_sync within timeout
// - after absent_memory the bus address holds failing address plus two, or the failing address itself while address_hold is set
// - set program_conflict when transfer start arrives while one runs
// - on program_conflict the offending transfer command is not written
// - set missed_transfer when drive does not answer within 250 ms
// - missed_transfer is readable and writable by software
// - missed_transfer also on drive error summary or failed start
// - set drive data parity error on read or write-check parity fault
// - write-direction parity errors are left to the drive's own register
// - error flags clear on init, controller clear, error clear, go
// - each error flag feeds the transfer_error summary
// - output-ready while buffer word waits; clears on init, clear, read
// - data buffer read before output-ready raises data_late
// - input-ready when software may write the buffer; cleared by read
// - data buffer write before input-ready raises data_late
// - writing controller_clear one initializes controller and drives
// - bus init performs the same controller clear
// - parity_test_invert selects even parity out, else odd
// - with parity_test_invert expect even data parity, no control check
// - address_hold stops bus address increment during transfers
// - unit select picks drive, cleared by clear, changeable mid-transfer
// - set data_late when drive demands a word that is not ready
module ctrl_status2_bits (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  output logic [15:0] mem_addr_o,
  output logic mem_sync_o,
  input wire logic mem_ack_i,
  output logic drive_cmd_o,
  input wire logic drive_start_i,
  input wire logic drive_err_sum_i,
  input wire logic drive_reject_i,
  input wire logic drive_demand_i,
  input wire logic drive_read_dir_i,
  input wire logic [15:0] drive_data_i,
  input wire logic drive_data_par_i,
  output logic drive_par_even_o,
  output logic [2:0] unit_sel_o,
  output logic drives_init_o,
  output logic transfer_error_o,
  output logic ctrl_ready_o
);

  //----------------------------------------------------------------
  // decode and clear sources
  //----------------------------------------------------------------
  ctrl_status2_pkg::dma_state_t state;
  ctrl_status2_pkg::dma_state_t next_state;
  logic [15:0] data_buffer;
  logic [15:0] bus_address_reg;
  logic [2:0] unit_sel;
  logic [27:0] tmo_cnt;
  logic absent_memory, program_conflict, missed_transfer;
  logic drive_data_parity_err, data_late;
  logic out_ready, input_ready;
  logic parity_test_invert, address_hold;
  logic busy;
  logic wr_cs2, wr_cmd, rd_dbuf, wr_dbuf;
  logic controller_clear, ctrl_reset, go_xfer, err_clear, flag_clear;
  logic start_req, rx_par_bad;

  // address decode
  always_comb begin
    wr_cs2 = 1'b0;
    wr_cmd = 1'b0;
    rd_dbuf = 1'b0;
    wr_dbuf = 1'b0;
    if (addr_i == ctrl_status2_pkg::OFF_CS2) begin
      wr_cs2 = wr_i;
    end else if (addr_i == ctrl_status2_pkg::OFF_CMD) begin
      wr_cmd = wr_i;
    end else if (addr_i == ctrl_status2_pkg::OFF_DBUF) begin
      rd_dbuf = rd_i;
      wr_dbuf = wr_i;
    end
  end

  // controller clear is write-only and also driven by bus init
  assign controller_clear = wr_cs2 & wdata_i[ctrl_status2_pkg::BIT_CCLR];
  assign ctrl_reset = rst_i | controller_clear;
  assign drives_init_o = ctrl_reset;
  assign start_req = wr_cmd & wdata_i[ctrl_status2_pkg::BIT_GO]
                   & wdata_i[ctrl_status2_pkg::BIT_XFER];
  assign busy = (state != ctrl_status2_pkg::DMA_IDLE);
  // a start while busy is refused, so it never clears the flags
  assign go_xfer = start_req & ~busy;
  assign err_clear = wr_cmd & wdata_i[ctrl_status2_pkg::BIT_ECLR];
  assign flag_clear = ctrl_reset | err_clear | go_xfer;

  // odd parity normally, even while the test bit is set
  function automatic logic par_bit(input logic [15:0] d, input logic even);
    par_bit = even ? ^d : ~(^d);
  endfunction

  // received data parity, only data bus is checked
  assign rx_par_bad = drive_demand_i & drive_read_dir_i & (drive_data_par_i
    != par_bit(drive_data_i, parity_test_invert));

  //----------------------------------------------------------------
  // transfer engine
  //----------------------------------------------------------------
  // dma sequencing between drive start and memory cycles
  always_comb begin
    next_state = state;
    case (state)
      ctrl_status2_pkg::DMA_IDLE: begin
        if (go_xfer) begin
          next_state = ctrl_status2_pkg::DMA_WAIT_DRV;
        end
      end
      ctrl_status2_pkg::DMA_WAIT_DRV: begin
        if (drive_err_sum_i | drive_reject_i) begin
          next_state = ctrl_status2_pkg::DMA_IDLE;
        end else if (tmo_cnt ==
            28'(ctrl_status2_pkg::XFER_TMO_CYC - 1)) begin
          next_state = ctrl_status2_pkg::DMA_IDLE;
        end else if (drive_start_i) begin
          next_state = ctrl_status2_pkg::DMA_MEM;
        end
      end
      ctrl_status2_pkg::DMA_MEM: begin
        if (mem_ack_i) begin
          next_state = ctrl_status2_pkg::DMA_IDLE;
        end else if (tmo_cnt ==
            28'(ctrl_status2_pkg::MEM_TMO_CYC - 1)) begin
          next_state = ctrl_status2_pkg::DMA_IDLE;
        end
      end
      default: begin
        next_state = ctrl_status2_pkg::DMA_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock_i) begin
    if (ctrl_reset) begin
      state <= ctrl_status2_pkg::DMA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // timeout counter restarts on every state change
  always_ff @(posedge clock_i) begin
    if (ctrl_reset || next_state != state) begin
      tmo_cnt <= 28'h000_0000;
    end else if (busy) begin
      tmo_cnt <= tmo_cnt + 28'h000_0001;
    end
  end

  // bus address: step by two per word unless held
  always_ff @(posedge clock_i) begin
    if (ctrl_reset) begin
      bus_address_reg <= ctrl_status2_pkg::BADDR_RST;
    end else if (wr_i && addr_i == ctrl_status2_pkg::OFF_BADDR && !busy) begin
      bus_address_reg <= wdata_i;
    end else if (state == ctrl_status2_pkg::DMA_MEM && !address_hold &&
        (mem_ack_i || next_state == ctrl_status2_pkg::DMA_IDLE)) begin
      // a timeout also steps, leaving failing address plus two
      bus_address_reg <= bus_address_reg
                       + ctrl_status2_pkg::ADDR_STEP;
    end
  end

  //----------------------------------------------------------------
  // error flags (set wins over clear)
  //----------------------------------------------------------------
  // absent memory
  always_ff @(posedge clock_i) begin
    if (state == ctrl_status2_pkg::DMA_MEM && !mem_ack_i &&
        tmo_cnt == 28'(ctrl_status2_pkg::MEM_TMO_CYC - 1)) begin
      absent_memory <= 1'b1;
    end else if (flag_clear) begin
      absent_memory <= 1'b0;
    end
  end

  // program conflict
  always_ff @(posedge clock_i) begin
    if (start_req && busy && !rst_i) begin
      program_conflict <= 1'b1;
    end else if (flag_clear) begin
      program_conflict <= 1'b0;
    end
  end

  // missed transfer, also software writable
  always_ff @(posedge clock_i) begin
    if (state == ctrl_status2_pkg::DMA_WAIT_DRV && (drive_err_sum_i ||
        drive_reject_i || tmo_cnt ==
        28'(ctrl_status2_pkg::XFER_TMO_CYC - 1))) begin
      missed_transfer <= 1'b1;
    end else if (flag_clear) begin
      missed_transfer <= 1'b0;
    end else if (wr_cs2) begin
      missed_transfer <= wdata_i[ctrl_status2_pkg::BIT_MISSED];
    end
  end

  // drive data parity, read direction only
  always_ff @(posedge clock_i) begin
    if (rx_par_bad && !rst_i) begin
      drive_data_parity_err <= 1'b1;
    end else if (flag_clear) begin
      drive_data_parity_err <= 1'b0;
    end
  end

  // data late from late software access or unserved drive demand
  always_ff @(posedge clock_i) begin
    if (!rst_i && ((rd_dbuf && !out_ready) || (wr_dbuf && !input_ready))) begin
      data_late <= 1'b1;
    end else if (!rst_i && drive_demand_i && (drive_read_dir_i ?
        out_ready : !out_ready)) begin
      data_late <= 1'b1;
    end else if (flag_clear) begin
      data_late <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // diagnostic data buffer
  //----------------------------------------------------------------
  // buffer word and output-ready
  always_ff @(posedge clock_i) begin
    if (ctrl_reset) begin
      out_ready <= 1'b0;
      data_buffer <= ctrl_status2_pkg::ZERO16;
    end else if (drive_demand_i && drive_read_dir_i && !out_ready) begin
      data_buffer <= drive_data_i;
      out_ready <= 1'b1;
    end else if (wr_dbuf && input_ready) begin
      data_buffer <= wdata_i;
      out_ready <= 1'b1;
    end else if (rd_dbuf) begin
      out_ready <= 1'b0;
    end
  end

  // input-ready: set when buffer empties, cleared by a read
  always_ff @(posedge clock_i) begin
    if (ctrl_reset) begin
      input_ready <= 1'b1;
    end else if (rd_dbuf) begin
      input_ready <= 1'b0;
    end else if (wr_dbuf && input_ready) begin
      input_ready <= 1'b0;
    end else if (!out_ready) begin
      input_ready <= 1'b1;
    end
  end

  //----------------------------------------------------------------
  // control bits
  //----------------------------------------------------------------
  // parity test bit
  always_ff @(posedge clock_i) begin
    if (ctrl_reset) begin
      parity_test_invert <= 1'b0;
    end else if (wr_cs2) begin
      parity_test_invert <= wdata_i[ctrl_status2_pkg::BIT_PTEST];
    end
  end

  // address hold, locked while a transfer runs
  always_ff @(posedge clock_i) begin
    if (ctrl_reset) begin
      address_hold <= 1'b0;
    end else if (wr_cs2 && !busy) begin
      address_hold <= wdata_i[ctrl_status2_pkg::BIT_AHOLD];
    end
  end

  // unit select, free to change during transfers
  always_ff @(posedge clock_i) begin
    if (ctrl_reset) begin
      unit_sel <= ctrl_status2_pkg::UNIT_RST;
    end else if (wr_cs2) begin
      unit_sel <= wdata_i[2:0];
    end
  end

  //----------------------------------------------------------------
  // outputs and read-back
  //----------------------------------------------------------------
  assign unit_sel_o = unit_sel;
  assign mem_addr_o = bus_address_reg;
  assign mem_sync_o = (state == ctrl_status2_pkg::DMA_MEM);
  assign drive_cmd_o = (state == ctrl_status2_pkg::DMA_WAIT_DRV);
  assign drive_par_even_o = parity_test_invert;
  assign ctrl_ready_o = ~busy;
  assign transfer_error_o = absent_memory | program_conflict | missed_transfer
    | drive_data_parity_err | data_late;

  // read data register, one cycle after the strobe
  always_ff @(posedge clock_i) begin
    if (rst_i || !rd_i) begin
      rdata_o <= ctrl_status2_pkg::ZERO16;
    end else if (addr_i == ctrl_status2_pkg::OFF_CS2) begin
      rdata_o <= {data_late, 3'h0, absent_memory, program_conflict,
        missed_transfer, drive_data_parity_err, out_ready, input_ready,
        1'b0, parity_test_invert, address_hold, unit_sel};
    end else if (addr_i == ctrl_status2_pkg::OFF_DBUF) begin
      rdata_o <= data_buffer;
    end else if (addr_i == ctrl_status2_pkg::OFF_BADDR) begin
      rdata_o <= bus_address_reg;
    end else if (addr_i == ctrl_status2_pkg::OFF_STAT) begin
      rdata_o <= {14'h0000, transfer_error_o, ~busy};
    end else begin
      rdata_o <= ctrl_status2_pkg::ZERO16;
    end
  end

endmodule

//--- inc/ctrl_status2_pkg.sv
// constants for the second control and status register bank
package ctrl_status2_pkg;
  // register offsets on the plain register port (word index)
  localparam logic [3:0] OFF_CS2 = 4'h0;
  localparam logic [3:0] OFF_DBUF = 4'h1;
  localparam logic [3:0] OFF_BADDR = 4'h2;
  localparam logic [3:0] OFF_CMD = 4'h3;
  localparam logic [3:0] OFF_STAT = 4'h4;
  // bit positions of the second control and status register
  localparam int BIT_DLATE = 15;
  localparam int BIT_ABSENT = 11;
  localparam int BIT_PCONF = 10;
  localparam int BIT_MISSED = 9;
  localparam int BIT_DPAR = 8;
  localparam int BIT_ORDY = 7;
  localparam int BIT_IRDY = 6;
  localparam int BIT_CCLR = 5;
  localparam int BIT_PTEST = 4;
  localparam int BIT_AHOLD = 3;
  // command register fields
  localparam int BIT_GO = 0;
  localparam int BIT_XFER = 1;
  localparam int BIT_ECLR = 2;
  // reset values
  localparam logic [2:0] UNIT_RST = 3'h0;
  localparam logic [15:0] BADDR_RST = 16'h0000;
  localparam logic [15:0] ZERO16 = 16'h0000;
  localparam logic [15:0] ADDR_STEP = 16'h0002;
  // timing: 200 MHz clock
  localparam int CLK_MHZ = 200;
  localparam int MEM_TMO_US = 10;
  localparam int MEM_TMO_CYC = MEM_TMO_US * CLK_MHZ;
  localparam int XFER_TMO_MS = 250;
  localparam int XFER_TMO_CYC = XFER_TMO_MS * 1000 * CLK_MHZ;
  // dma engine states
  typedef enum logic [1:0] {
    DMA_IDLE = 2'b00,
    DMA_WAIT_DRV = 2'b01,
    DMA_MEM = 2'b10
  } dma_state_t;
endpackage

//--- sim/ctrl_status2_properties.sv
// assertion checker for the second control and status register bank
`timescale 1ns/1ps
module ctrl_status2_properties (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic [15:0] mem_addr_o,
  input wire logic mem_sync_o,
  input wire logic mem_ack_i,
  input wire logic drive_cmd_o,
  input wire logic drive_err_sum_i,
  input wire logic drive_reject_i,
  input wire logic drive_par_even_o,
  input wire logic [2:0] unit_sel_o,
  input wire logic drives_init_o,
  input wire logic transfer_error_o,
  input wire logic ctrl_ready_o
);
  logic hold;
  logic cs2_wr;
  assign cs2_wr = wr_i && addr_i == ctrl_status2_pkg::OFF_CS2;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  // shadow of the hold bit, only writable while idle
  always_ff @(posedge clock_i) begin
    if (rst_i || drives_init_o) begin
      hold <= 1'b0;
    end else if (cs2_wr && ctrl_ready_o) begin
      hold <= wdata_i[ctrl_status2_pkg::BIT_AHOLD];
    end
  end
  // --------------------------------------------------------------
  // sequences and assertions
  // --------------------------------------------------------------
  sequence start_req;
    wr_i && addr_i == ctrl_status2_pkg::OFF_CMD && wdata_i[1:0] == 2'b11;
  endsequence
  sequence mem_done;
    $fell(mem_sync_o) && !$past(rst_i) && !$past(drives_init_o);
  endsequence
  init_pulse_a: assert property (disable iff (1'b0)
    rst_i || (cs2_wr && wdata_i[5]) |-> drives_init_o)
    else $error("drive init missing");
  clear_state_a: assert property (disable iff (1'b0)
    rst_i |=> ctrl_ready_o && unit_sel_o == 3'h0 && !drive_par_even_o
      && !transfer_error_o && !mem_sync_o)
    else $error("state not cleared by init");
  unit_write_a: assert property (cs2_wr |=>
    unit_sel_o == ($past(wdata_i[5]) ? 3'h0 : $past(wdata_i[2:0])))
    else $error("unit select not written");
  ptest_write_a: assert property (cs2_wr |=>
    drive_par_even_o == ($past(wdata_i[5]) ? 1'b0 : $past(wdata_i[4])))
    else $error("parity test not written");
  summary_read_a: assert property (
    rd_i && addr_i == ctrl_status2_pkg::OFF_CS2 |=> rdata_o[5] == 1'b0
      && $past(transfer_error_o) == |{rdata_o[15], rdata_o[11:8]})
    else $error("error summary disagrees with flags");
  conflict_a: assert property (
    start_req ##0 !ctrl_ready_o |=> transfer_error_o)
    else $error("start while busy not flagged");
  go_start_a: assert property (
    start_req ##0 ctrl_ready_o |=> drive_cmd_o && !transfer_error_o)
    else $error("start did not clear flags or issue command");
  refused_a: assert property (
    drive_cmd_o && (drive_err_sum_i || drive_reject_i)
      |=> transfer_error_o && !drive_cmd_o)
    else $error("refused command not flagged");
  mem_fail_a: assert property (
    mem_done ##0 !$past(mem_ack_i) |-> ##[0:1] transfer_error_o)
    else $error("memory timeout not flagged");
  addr_step_a: assert property (mem_done |-> mem_addr_o ==
    $past(mem_addr_o) + (hold ? 16'h0000 : ctrl_status2_pkg::ADDR_STEP))
    else $error("bus address step wrong");
endmodule
bind ctrl_status2_bits ctrl_status2_properties i_props (
  .clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .mem_addr_o(mem_addr_o),
  .mem_sync_o(mem_sync_o), .mem_ack_i(mem_ack_i),
  .drive_cmd_o(drive_cmd_o), .drive_err_sum_i(drive_err_sum_i),
  .drive_reject_i(drive_reject_i), .drive_par_even_o(drive_par_even_o),
  .unit_sel_o(unit_sel_o), .drives_init_o(drives_init_o),
  .transfer_error_o(transfer_error_o), .ctrl_ready_o(ctrl_ready_o));

//--- sim/drive_model.sv
// behavioural tape formatter on the drive side
`timescale 1ns/1ps
module drive_model (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic cmd_i,
  input wire logic even_i,
  input wire logic par_bad_i,
  input wire logic [1:0] mode_i,
  output logic start_o,
  output logic err_sum_o,
  output logic reject_o,
  output logic demand_o,
  output logic [15:0] data_o,
  output logic par_o
);
  localparam logic [15:0] WORD = 16'h5a3c;
  logic [7:0] cnt;
  assign err_sum_o = mode_i == 2'd2;
  // answer a pending command promptly, slowly or by refusing it
  always_ff @(posedge clock_i) begin
    cnt <= (rst_i || !cmd_i) ? 8'h00 : cnt + 8'h01;
    start_o <= cmd_i && !mode_i[1] && cnt == (mode_i[0] ? 8'h14 : 8'h01);
    reject_o <= cmd_i && mode_i == 2'd3 && cnt == 8'h03;
    demand_o <= start_o;
  end
  // one read word after start, a moving pattern once released
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      data_o <= 16'h0000;
      par_o <= 1'b0;
    end else begin
      data_o <= start_o ? WORD : ~data_o;
      par_o <= start_o ? (~^WORD) ^ even_i ^ par_bad_i : ~par_o;
    end
  end
endmodule

//--- sim/ctrl_status2_bits_tb.sv
// self-checking bench for the second control and status register bank
`timescale 1ns/1ps
module ctrl_status2_bits_tb;
  logic clock_i, rst_i, wr_i, rd_i, mem_ack_i, par_bad, mem_sync_o;
  logic [3:0] addr_i;
  logic [15:0] wdata_i, rdata_o, mem_addr_o, drive_data_i, rd_val;
  logic drive_cmd_o, drive_start_i, drive_err_sum_i, drive_reject_i;
  logic drive_demand_i, drive_data_par_i, drive_par_even_o, drives_init_o;
  logic transfer_error_o, ctrl_ready_o;
  logic [2:0] unit_sel_o;
  logic [1:0] mode;
  int err_count, compares, cycles, n;
  ctrl_status2_bits i_dut (.clock_i(clock_i), .rst_i(rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .mem_addr_o(mem_addr_o), .mem_sync_o(mem_sync_o),
    .mem_ack_i(mem_ack_i), .drive_cmd_o(drive_cmd_o),
    .drive_start_i(drive_start_i), .drive_err_sum_i(drive_err_sum_i),
    .drive_reject_i(drive_reject_i), .drive_demand_i(drive_demand_i),
    .drive_read_dir_i(1'b1), .drive_data_i(drive_data_i),
    .drive_data_par_i(drive_data_par_i),
    .drive_par_even_o(drive_par_even_o), .unit_sel_o(unit_sel_o),
    .drives_init_o(drives_init_o), .transfer_error_o(transfer_error_o),
    .ctrl_ready_o(ctrl_ready_o));
  drive_model i_drive (.clock_i(clock_i), .rst_i(rst_i),
    .cmd_i(drive_cmd_o), .even_i(drive_par_even_o), .par_bad_i(par_bad),
    .mode_i(mode), .start_o(drive_start_i), .err_sum_o(drive_err_sum_i),
    .reject_o(drive_reject_i), .demand_o(drive_demand_i),
    .data_o(drive_data_i), .par_o(drive_data_par_i));
  // 200 MHz clock
  initial begin
    clock_i = 1'b0;
    forever #2.5 clock_i = ~clock_i;
  end
  // hang guard
  always @(posedge clock_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      test_done();
    end
  end
  // --------------------------------------------------------------
  // bus tasks and compares
  // --------------------------------------------------------------
  task test_done;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
  endtask
  task rchk(input string name, input logic [3:0] a, input logic [15:0] mask,
            input logic [15:0] exp);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 rd_val = rdata_o;
    chk(name, exp, rd_val & mask);
  endtask
  task start(input logic [1:0] m, input logic bad);
    mode = m;
    par_bad = bad;
    wr(ctrl_status2_pkg::OFF_CMD, 16'h0003);
  endtask
  task finish(input logic ack);
    n = 0;
    do begin
      @(posedge clock_i);
      mem_ack_i <= ack && mem_sync_o;
      n++;
    end while (ctrl_ready_o !== 1'b1 && n < 3000);
    mem_ack_i <= 1'b0;
    chk("ready", 16'h0001, {15'h0000, ctrl_ready_o});
  endtask
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    {rst_i, wr_i, rd_i, mem_ack_i, par_bad, mode} = 7'h40;
    addr_i = 4'h0;
    wdata_i = 16'h0000;
    repeat (8) @(posedge clock_i);
    rst_i <= 1'b0;
    rchk("cs2 reset", 4'h0, 16'hffff, 16'h0040);
    wr(4'h0, 16'h001f);
    rchk("cs2 fields", 4'h0, 16'hffff, 16'h005f);
    chk("even parity", 16'h0001, {15'h0000, drive_par_even_o});
    wr(4'h0, 16'h0020);
    rchk("cs2 clear", 4'h0, 16'hffff, 16'h0040);
    // buffer empty after clear, so this read comes too early
    rchk("late read", 4'h1, 16'hffff, 16'h0000);
    rchk("cs2 late read", 4'h0, 16'hffff, 16'h8040);
    wr(4'h3, 16'h0004);
    rchk("error clear", 4'h0, 16'hffff, 16'h0040);
    // first write fills the buffer, the second one is too early
    wr(4'h1, 16'h1234);
    wr(4'h1, 16'h4321);
    rchk("late write", 4'h0, 16'hffff, 16'h8080);
    wr(4'h0, 16'h0020);
    wr(4'h0, 16'h0200);
    rchk("missed set", 4'h0, 16'hffff, 16'h0240);
    rchk("summary", 4'h4, 16'h0002, 16'h0002);
    wr(4'h0, 16'h0000);
    rchk("missed clear", 4'h0, 16'hffff, 16'h0040);
    wr(4'h2, 16'h0100);
    start(2'd1, 1'b0);
    wr(4'h3, 16'h0003);
    wr(4'h0, 16'h000d);
    rchk("busy writes", 4'h0, 16'h040f, 16'h0405);
    finish(1'b1);
    rchk("address step", 4'h2, 16'hffff, 16'h0102);
    wr(4'h0, 16'h0018);
    start(2'd0, 1'b0);
    finish(1'b1);
    rchk("go clears", 4'h0, 16'h0f00, 16'h0000);
    rchk("address held", 4'h2, 16'hffff, 16'h0102);
    wr(4'h0, 16'h0000);
    start(2'd0, 1'b1);
    finish(1'b0);
    rchk("no memory", 4'h0, 16'h0900, 16'h0900);
    rchk("fail address", 4'h2, 16'hffff, 16'h0104);
    for (int m = 2; m < 4; m++) begin
      start(2'(m), 1'b0);
      finish(1'b0);
      rchk("refused", 4'h0, 16'h0200, 16'h0200);
    end
    mode = 2'd0;
    @(posedge clock_i);
    rst_i <= 1'b1;
    @(posedge clock_i);
    rst_i <= 1'b0;
    rchk("init clear", 4'h0, 16'hffff, 16'h0040);
    test_done();
  end
endmodule
